// file: rtl/ddbp_regs.svh
// Constants of the download data block packetizer
`ifndef DDBP_REGS_SVH
`define DDBP_REGS_SVH

// Transport header
`define DDBP_SYNC_BYTE 8'h47
`define DDBP_TEI 1'h0
`define DDBP_PUSI 1'h1
`define DDBP_PRIO 1'h0
`define DDBP_SCRAMBLE 2'h0
`define DDBP_AFC 2'h1
`define DDBP_CC_RST 4'h0
`define DDBP_POINTER 8'h00

// Section header
`define DDBP_TABLE_ID 8'h3C
`define DDBP_SSI 1'h0
`define DDBP_RSVD2 2'h3
`define DDBP_CNI 1'h1
`define DDBP_SECT_FIXED 12'h01B

// Message header
`define DDBP_PROTO_DISC 8'h11
`define DDBP_DSMCC_TYPE 8'h03
`define DDBP_MSG_ID 16'h1003
`define DDBP_RSVD_BYTE 8'hFF
`define DDBP_ADAPT_LEN 8'h00
`define DDBP_MSG_FIXED 16'h0006

// Trailer and packet geometry
`define DDBP_CHECKSUM 32'h00000000
`define DDBP_PAD_BYTE 8'hFF
`define DDBP_PKT_LAST 8'hBB
`define DDBP_HDR_LEN 8'h1F
`define DDBP_SUM_LEN 8'h04
`define DDBP_MAX_PAY 8'h99

`endif

// file: rtl/ddbp_pkg.sv
// Types of the download data block packetizer
package ddbp_pkg;

    // Packet sequencer states
    typedef enum logic [1:0] {
        DDBP_IDLE,
        DDBP_RUN,
        DDBP_DRAIN
    } ddbp_state_t;

endpackage

// file: rtl/ddbp_framer.sv
// Framer that emits one transport packet holding a download data block
//
// How it works
// - Payload unit start bit is one since the section starts here.
// - Configured 13-bit packet identifier goes into the header.
// - Scrambling control bits are zero: payload is unscrambled.
// - Adaptation field control is 01: payload only.
// - First payload byte is a zero pointer.
// - Table identifier byte is 0x3C for download data blocks.
// - Syntax indicator zero; private bit is its inverse.
// - Every reserved bit and byte is sent as all ones.
// - Section length counts extension through checksum end.
// - Table identifier extension copies the module identifier.
// - Section version is low five bits of module version.
// - Current/next bit is always one.
// - Section number is low block number byte; last is configured.
// - Download identifier carries the configured carousel identifier.
// - Adaptation length is zero, no time stamp inserted.
// - Message length counts bytes after it, excluding checksum.
// - Block header carries the 16-bit module identifier.
// - Block number gives position in module, first is zero.
// - Module data bytes are copied unchanged as N-byte payload, N cut to 153.
// - Checksum trailer is written as zero: none computed.
`timescale 1ns/1ns
`include "ddbp_regs.svh"

module ddbp_framer (
    input wire logic mclk_in,                 // 25 MHz clock
    input wire logic rst_b_in,                // Sync reset, active low
    input wire logic start_in,                // Start a packet (idle only)
    input wire logic [12:0] pid_in,           // Packet identifier
    input wire logic [15:0] module_id_in,     // Module identifier
    input wire logic [7:0] module_version_in, // Module version
    input wire logic [15:0] block_number_in,  // Block position in module
    input wire logic [7:0] last_section_in,   // Last section number
    input wire logic [31:0] download_id_in,   // Carousel identifier
    input wire logic [7:0] block_len_in,      // Payload bytes N
    input wire logic [7:0] data_in,           // Module data byte
    input wire logic data_valid_in,           // Module data byte valid
    output logic data_ready_out,              // Module data byte taken
    output logic [7:0] ts_data_out,           // Packet byte
    output logic ts_valid_out,                // Packet byte valid
    output logic ts_sop_out,                  // First byte of packet
    output logic ts_eop_out,                  // Last byte of packet
    input wire logic ts_ready_in,             // Sink takes byte
    output logic busy_out                     // Packet in progress
);

    ddbp_pkg::ddbp_state_t state;
    ddbp_pkg::ddbp_state_t next_state;
    logic [7:0] pos;
    logic [7:0] next_pos;

    // Configuration captured at start
    // Held for the whole packet so inputs may change after start
    logic [12:0] cfg_pid;
    logic [12:0] next_cfg_pid;
    logic [15:0] cfg_mod_id;
    logic [15:0] next_cfg_mod_id;
    logic [7:0] cfg_mod_ver;
    logic [7:0] next_cfg_mod_ver;
    logic [15:0] cfg_blk;
    logic [15:0] next_cfg_blk;
    logic [7:0] cfg_last;
    logic [7:0] next_cfg_last;
    logic [31:0] cfg_dl_id;
    logic [31:0] next_cfg_dl_id;
    logic [7:0] cfg_len;
    logic [7:0] next_cfg_len;
    logic [3:0] cfg_cc;
    logic [3:0] next_cfg_cc;

    // Continuity tracking across packets
    // Remembered only once a packet has loaded its last byte
    logic [3:0] cc;
    logic [3:0] next_cc;
    logic [12:0] last_pid;
    logic [12:0] next_last_pid;
    logic pid_seen;
    logic next_pid_seen;

    // Output byte register
    logic [7:0] next_ts_data;
    logic next_ts_valid;
    logic next_ts_sop;
    logic next_ts_eop;

    // Derived lengths and phase borders
    logic [11:0] sect_len;
    logic [15:0] msg_len;
    logic [7:0] pay_end;
    logic [7:0] sum_end;
    logic [7:0] sum_idx;
    logic [7:0] hdr_byte;
    logic [7:0] cur_byte;
    logic in_pay;
    logic out_free;
    logic load;
    logic [31:0] checksum;

    // Lengths grow with the payload; fixed parts are constants
    // Clamping N to 153 keeps both inside their field widths
    assign sect_len = `DDBP_SECT_FIXED + {4'h0, cfg_len};
    assign msg_len = `DDBP_MSG_FIXED + {8'h00, cfg_len};
    assign pay_end = `DDBP_HDR_LEN + cfg_len;
    assign sum_end = pay_end + `DDBP_SUM_LEN;
    assign sum_idx = pos - pay_end;
    assign checksum = `DDBP_CHECKSUM;

    // Phase and handshake terms
    assign in_pay = (pos >= `DDBP_HDR_LEN) && (pos < pay_end);
    // Free when empty, or when the held byte is taken this edge
    assign out_free = !ts_valid_out || ts_ready_in;
    // Payload bytes stall the packet until the source offers one
    assign load = (state == ddbp_pkg::DDBP_RUN) && out_free &&
                  (!in_pay || data_valid_in);
    assign data_ready_out = (state == ddbp_pkg::DDBP_RUN) && out_free &&
                            in_pay;
    assign busy_out = (state != ddbp_pkg::DDBP_IDLE);

    // Fixed header bytes by position
    // Message header constants at 13 to 16 are not configurable
    always_comb begin
        hdr_byte = `DDBP_PAD_BYTE;
        unique case (pos)
            8'h00: hdr_byte = `DDBP_SYNC_BYTE;
            8'h01: hdr_byte = {`DDBP_TEI, `DDBP_PUSI, `DDBP_PRIO,
                               cfg_pid[12:8]};
            8'h02: hdr_byte = cfg_pid[7:0];
            8'h03: hdr_byte = {`DDBP_SCRAMBLE, `DDBP_AFC,
                               cfg_cc};
            8'h04: hdr_byte = `DDBP_POINTER;
            8'h05: hdr_byte = `DDBP_TABLE_ID;
            8'h06: hdr_byte = {`DDBP_SSI, ~`DDBP_SSI, `DDBP_RSVD2,
                               sect_len[11:8]};
            8'h07: hdr_byte = sect_len[7:0];
            8'h08: hdr_byte = cfg_mod_id[15:8];
            8'h09: hdr_byte = cfg_mod_id[7:0];
            8'h0A: hdr_byte = {`DDBP_RSVD2, cfg_mod_ver[4:0],
                               `DDBP_CNI};
            8'h0B: hdr_byte = cfg_blk[7:0];
            8'h0C: hdr_byte = cfg_last;
            8'h0D: hdr_byte = `DDBP_PROTO_DISC;
            8'h0E: hdr_byte = `DDBP_DSMCC_TYPE;
            8'h0F: hdr_byte = 8'(`DDBP_MSG_ID >> 8);
            8'h10: hdr_byte = 8'(`DDBP_MSG_ID & 16'h00FF);
            8'h11: hdr_byte = cfg_dl_id[31:24];
            8'h12: hdr_byte = cfg_dl_id[23:16];
            8'h13: hdr_byte = cfg_dl_id[15:8];
            8'h14: hdr_byte = cfg_dl_id[7:0];
            8'h15: hdr_byte = `DDBP_RSVD_BYTE;
            8'h16: hdr_byte = `DDBP_ADAPT_LEN;
            8'h17: hdr_byte = msg_len[15:8];
            8'h18: hdr_byte = msg_len[7:0];
            8'h19: hdr_byte = cfg_mod_id[15:8];
            8'h1A: hdr_byte = cfg_mod_id[7:0];
            8'h1B: hdr_byte = cfg_mod_ver;
            8'h1C: hdr_byte = `DDBP_RSVD_BYTE;
            8'h1D: hdr_byte = cfg_blk[15:8];
            8'h1E: hdr_byte = cfg_blk[7:0];
            default: hdr_byte = `DDBP_PAD_BYTE;
        endcase
    end

    // Byte for the current position across all phases
    always_comb begin
        cur_byte = `DDBP_PAD_BYTE;
        if (pos < `DDBP_HDR_LEN) begin
            cur_byte = hdr_byte;
        end else if (in_pay) begin
            cur_byte = data_in;
        end else if (pos < sum_end) begin
            // Checksum word follows the payload, MSB first
            unique case (sum_idx[1:0])
                2'h0: cur_byte = checksum[31:24];
                2'h1: cur_byte = checksum[23:16];
                2'h2: cur_byte = checksum[15:8];
                2'h3: cur_byte = checksum[7:0];
            endcase
        end
    end

    // Sequencer, configuration capture and continuity next values
    always_comb begin
        next_state = state;
        next_pos = pos;
        next_cfg_pid = cfg_pid;
        next_cfg_mod_id = cfg_mod_id;
        next_cfg_mod_ver = cfg_mod_ver;
        next_cfg_blk = cfg_blk;
        next_cfg_last = cfg_last;
        next_cfg_dl_id = cfg_dl_id;
        next_cfg_len = cfg_len;
        next_cfg_cc = cfg_cc;
        next_cc = cc;
        next_last_pid = last_pid;
        next_pid_seen = pid_seen;
        unique case (state)
            ddbp_pkg::DDBP_IDLE: begin
                // A start seen in any other state is ignored
                if (start_in) begin
                    next_state = ddbp_pkg::DDBP_RUN;
                    next_pos = 8'h00;
                    next_cfg_pid = pid_in;
                    next_cfg_mod_id = module_id_in;
                    next_cfg_mod_ver = module_version_in;
                    next_cfg_blk = block_number_in;
                    next_cfg_last = last_section_in;
                    next_cfg_dl_id = download_id_in;
                    // Oversize blocks are cut to fit one packet
                    next_cfg_len = (block_len_in > `DDBP_MAX_PAY) ?
                                   `DDBP_MAX_PAY : block_len_in;
                    // A new PID restarts its counter at zero
                    next_cfg_cc = (pid_seen && pid_in == last_pid) ?
                                  cc : `DDBP_CC_RST;
                end
            end
            ddbp_pkg::DDBP_RUN: begin
                if (load) begin
                    // Last byte loaded; counter steps for the next packet
                    if (pos == `DDBP_PKT_LAST) begin
                        next_state = ddbp_pkg::DDBP_DRAIN;
                        next_cc = cfg_cc + 4'h1;
                        next_last_pid = cfg_pid;
                        next_pid_seen = 1'b1;
                    end else begin
                        next_pos = pos + 8'h01;
                    end
                end
            end
            ddbp_pkg::DDBP_DRAIN: begin
                // Busy stays up until the sink takes the last byte
                if (ts_ready_in) begin
                    next_state = ddbp_pkg::DDBP_IDLE;
                end
            end
            default: begin
                next_state = ddbp_pkg::DDBP_IDLE;
            end
        endcase
    end

    // Output byte register next values
    // A loaded byte waits here until taken, so a stall loses nothing
    always_comb begin
        next_ts_data = ts_data_out;
        next_ts_valid = ts_valid_out;
        next_ts_sop = ts_sop_out;
        next_ts_eop = ts_eop_out;
        if (load) begin
            next_ts_data = cur_byte;
            next_ts_valid = 1'b1;
            next_ts_sop = (pos == 8'h00);
            next_ts_eop = (pos == `DDBP_PKT_LAST);
        end else if (ts_ready_in) begin
            next_ts_valid = 1'b0;
        end
    end

    // State registers
    // Reset also forgets the last PID, so the next counter starts at 0
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            state <= ddbp_pkg::DDBP_IDLE;
            pos <= 8'h00;
            cfg_pid <= 13'h0000;
            cfg_mod_id <= 16'h0000;
            cfg_mod_ver <= 8'h00;
            cfg_blk <= 16'h0000;
            cfg_last <= 8'h00;
            cfg_dl_id <= 32'h00000000;
            cfg_len <= 8'h00;
            cfg_cc <= `DDBP_CC_RST;
            cc <= `DDBP_CC_RST;
            last_pid <= 13'h0000;
            pid_seen <= 1'b0;
            ts_data_out <= 8'h00;
            ts_valid_out <= 1'b0;
            ts_sop_out <= 1'b0;
            ts_eop_out <= 1'b0;
        end else begin
            state <= next_state;
            pos <= next_pos;
            cfg_pid <= next_cfg_pid;
            cfg_mod_id <= next_cfg_mod_id;
            cfg_mod_ver <= next_cfg_mod_ver;
            cfg_blk <= next_cfg_blk;
            cfg_last <= next_cfg_last;
            cfg_dl_id <= next_cfg_dl_id;
            cfg_len <= next_cfg_len;
            cfg_cc <= next_cfg_cc;
            cc <= next_cc;
            last_pid <= next_last_pid;
            pid_seen <= next_pid_seen;
            ts_data_out <= next_ts_data;
            ts_valid_out <= next_ts_valid;
            ts_sop_out <= next_ts_sop;
            ts_eop_out <= next_ts_eop;
        end
    end

endmodule

// file: dv/ddbp_framer_asserts.sv
// Checker of the framer packet byte stream
`timescale 1ns/1ns
module ddbp_framer_asserts (
    input wire logic mclk_in, // Clock
    input wire logic rst_b_in, // Sync reset
    input wire logic [7:0] ts_data_out, // Byte
    input wire logic ts_valid_out, // Valid
    input wire logic ts_sop_out, // First byte
    input wire logic ts_eop_out, // Last byte
    input wire logic ts_ready_in, // Sink ready
    input wire logic busy_out // Busy
);
    logic [7:0] pos;
    logic [7:0] next_pos;
    logic take;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    // Place of the offered byte, so header fields can be pinned
    always_comb begin
        take = ts_valid_out && ts_ready_in;
        next_pos = pos;
        if (take) begin
            next_pos = ts_eop_out ? 8'h00 : pos + 8'h01;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            pos <= 8'h00;
        end else begin
            pos <= next_pos;
        end
    end
    AST_SYNC: assert property (ts_valid_out && pos == 8'h00 |->
        ts_sop_out && ts_data_out == 8'h47) else $error("bad sync");
    AST_PUSI: assert property (ts_valid_out && pos == 8'h01 |->
        ts_data_out[7:5] == 3'h2) else $error("bad start bit");
    AST_AFC: assert property (ts_valid_out && pos == 8'h03 |->
        ts_data_out[7:4] == 4'h1) else $error("bad control bits");
    AST_PTR: assert property (ts_valid_out && pos == 8'h04 |->
        ts_data_out == 8'h00) else $error("bad pointer");
    AST_TID: assert property (ts_valid_out && pos == 8'h05 |->
        ts_data_out == 8'h3C) else $error("bad table id");
    AST_SSI: assert property (ts_valid_out && pos == 8'h06 |->
        ts_data_out[7:4] == 4'h7) else $error("bad syntax bits");
    AST_CNI: assert property (ts_valid_out && pos == 8'h0A |->
        ts_data_out[0] && ts_data_out[7:6] == 2'h3) else $error("bad cni");
    AST_EOP: assert property (ts_valid_out && ts_eop_out |->
        pos == 8'hBB && !ts_sop_out) else $error("bad packet size");
    AST_HOLD: assert property (ts_valid_out && !ts_ready_in |=>
        ts_valid_out && $stable(ts_data_out)) else $error("byte dropped");
    AST_DONE: assert property (take && ts_eop_out |=>
        !busy_out && !ts_valid_out) else $error("no packet end");
    // Main scenarios reached
    C_END: cover property (take && ts_eop_out);
    C_STALL: cover property (ts_valid_out && !ts_ready_in ##1 ts_ready_in);
    C_SOP: cover property (take && ts_sop_out);
endmodule
bind ddbp_framer ddbp_framer_asserts u_chk (
    .mclk_in, .rst_b_in, .ts_data_out, .ts_valid_out,
    .ts_sop_out, .ts_eop_out, .ts_ready_in, .busy_out
);

// file: dv/ddbp_sink.sv
// Model of the stream multiplexer that takes packet bytes
`timescale 1ns/1ns
module ddbp_sink (
    input wire logic mclk_in, // Clock
    input wire logic [7:0] ts_data_in, // Byte
    input wire logic ts_valid_in, // Valid
    output logic ts_ready_out // Taken
);
    logic [7:0] q [$];
    integer seed = 32'h96FC15CF;
    initial ts_ready_out = 1'b0;
    // Stalls at random, as a busy mux would, to test holding
    always @(posedge mclk_in) begin
        if (ts_valid_in === 1'b1 && ts_ready_out) begin
            q.push_back(ts_data_in);
        end
        #1;
        ts_ready_out = ($random(seed) % 4) != 0;
    end
endmodule

// file: dv/test_ddbp_framer.sv
// Self-checking bench of the download data block framer
`timescale 1ns/1ns
module test_ddbp_framer;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic start_in = 1'b0;
    logic [12:0] pid_in = 13'h0000;
    logic [15:0] module_id_in = 16'h0000;
    logic [7:0] module_version_in = 8'h00;
    logic [15:0] block_number_in = 16'h0000;
    logic [7:0] last_section_in = 8'h00;
    logic [31:0] download_id_in = 32'h00000000;
    logic [7:0] block_len_in = 8'h00;
    logic [7:0] data_in = 8'h00;
    logic data_valid_in = 1'b0;
    logic data_ready_out, ts_valid_out, ts_sop_out, ts_eop_out;
    logic busy_out, ts_ready_in, tk;
    logic [7:0] ts_data_out;
    logic [7:0] src [256];
    logic [3:0] cc = 4'h0;
    logic [13:0] lpid = 14'h2000;
    int didx = 0, dn = 0, bad_count = 0, compares = 0, i;
    integer seed = 32'h96FC15CF;
    always #20 mclk_in = ~mclk_in;
    ddbp_framer uut (.mclk_in, .rst_b_in, .start_in, .pid_in,
        .module_id_in, .module_version_in, .block_number_in,
        .last_section_in, .download_id_in, .block_len_in, .data_in,
        .data_valid_in, .data_ready_out, .ts_data_out, .ts_valid_out,
        .ts_sop_out, .ts_eop_out, .ts_ready_in, .busy_out);
    ddbp_sink u_sink (.mclk_in, .ts_data_in(ts_data_out),
        .ts_valid_in(ts_valid_out), .ts_ready_out(ts_ready_in));
    task automatic finish_test();
        $display("bad_count=%0d compares=%0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    // Module data source; a byte on offer is held until taken
    always @(posedge mclk_in) begin
        tk = data_valid_in === 1'b1 && data_ready_out === 1'b1;
        #1;
        if (tk) didx++;
        if (tk || !data_valid_in || didx >= dn) begin
            data_valid_in = didx < dn && ($random(seed) % 3) != 0;
        end
        data_in = src[didx[7:0]];
    end
    // One packet: model image, start, refused restart, compare
    task automatic run(input logic [12:0] p, input logic [7:0] n,
            input logic rnd);
        logic [247:0] hdr;
        logic [7:0] e, nn;
        int k;
        @(posedge mclk_in);
        #1;
        nn = (n > 8'h99) ? 8'h99 : n;
        cc = ({1'b0, p} === lpid) ? cc + 4'h1 : 4'h0;
        lpid = {1'b0, p};
        for (k = 0; k < 256; k++) src[k] = 8'($random(seed));
        pid_in = p;
        block_len_in = n;
        module_id_in = rnd ? 16'($random(seed)) : 16'h0002;
        block_number_in = rnd ? 16'($random(seed)) : 16'h0000;
        module_version_in = rnd ? 8'($random(seed)) : 8'h00;
        last_section_in = rnd ? 8'($random(seed)) : 8'h00;
        download_id_in = rnd ? 32'($random(seed)) : 32'h00000000;
        hdr = {8'h47, 3'h2, pid_in, 4'h1, cc, 8'h00, 8'h3C, 4'h7,
            12'(nn + 8'h1B), module_id_in, 2'h3, module_version_in[4:0],
            1'h1, block_number_in[7:0], last_section_in, 8'h11, 8'h03,
            16'h1003, download_id_in, 8'hFF, 8'h00, 16'(nn + 8'h06),
            module_id_in, module_version_in, 8'hFF, block_number_in};
        didx = 0;
        dn = nn;
        u_sink.q.delete();
        start_in = 1'b1;
        @(posedge mclk_in);
        #1;
        start_in = 1'b0;
        // Scrambled after start: fields must come from the start edge
        pid_in = ~pid_in;
        module_id_in = ~module_id_in;
        block_len_in = 8'h05;
        repeat (20) @(posedge mclk_in);
        #1;
        start_in = 1'b1;
        @(posedge mclk_in);
        #1;
        start_in = 1'b0;
        for (k = 0; k < 4000 && (busy_out !== 1'b0
                || u_sink.q.size() < 188); k++) begin
            @(posedge mclk_in);
            #1;
        end
        if (k == 4000) begin
            bad_count++;
            finish_test();
        end
        repeat (3) @(posedge mclk_in);
        #1;
        chkb(busy_out, 1'b0); // No second packet
        chk(8'(u_sink.q.size()), 8'hBC); // Fixed size
        for (k = 0; k < 188; k++) begin
            e = (k < 31) ? hdr[247 - 8 * k -: 8] : (k < 31 + nn) ?
                src[k - 31] : (k < 35 + nn) ? 8'h00 : 8'hFF;
            chk(u_sink.q[k], e); // Byte image
        end
        chk(8'(didx), nn); // Bytes pulled
    endtask
    initial begin
        repeat (4) @(posedge mclk_in);
        #1;
        rst_b_in = 1'b1;
        chkb(busy_out, 1'b0); // Idle out of reset
        chkb(ts_valid_out, 1'b0); // Idle out of reset
        run(13'h00FF, 8'h2D, 1'b0); // Lengths 048 and 0033
        // Boundary lengths first, then random; counter wraps
        for (i = 0; i < 18; i++) begin
            run(13'h00FF, (i == 0) ? 8'h99 : (i == 1) ? 8'hC8 :
                (i == 2) ? 8'h00 : 8'({$random(seed)} % 154), 1'b1);
        end
        run(13'h1FFF, 8'h10, 1'b1); // New identifier
        start_in = 1'b1;
        @(posedge mclk_in);
        #1;
        start_in = 1'b0;
        repeat (40) @(posedge mclk_in);
        #1;
        rst_b_in = 1'b0;
        dn = 0;
        lpid = 14'h2000;
        repeat (2) @(posedge mclk_in);
        #1;
        rst_b_in = 1'b1;
        chkb(busy_out, 1'b0); // Abort by reset
        run(13'h1FFF, 8'h01, 1'b1); // Counter cleared
        finish_test();
    end
endmodule
